/* File: hw/upcs_consts.vh */
/*
  Constants for the cell port control/status register bank.
  Assumes byte addresses on the register port.
*/
`ifndef UPCS_CONSTS_VH
`define UPCS_CONSTS_VH
`define UPCS_ADDR_W        12
`define UPCS_CTRL_OFFSET   12'h600
`define UPCS_STAT_OFFSET   12'h602
`define UPCS_IE_OFFSET     12'h604
`define UPCS_CTRL_RESET    16'h0000
`define UPCS_STAT_RESET    16'h0000
`define UPCS_IE_RESET      16'h0000
`define UPCS_CTRL_RX_EN    0
`define UPCS_CTRL_PHY_ROLE 3
`define UPCS_CTRL_MULTIPHY 6
`define UPCS_CTRL_DRIVE    7
`define UPCS_CTRL_CLAV_OE  10
`define UPCS_CTRL_WMASK    16'h87FF
`define UPCS_STAT_ALARM    0
`define UPCS_STAT_RXLOSS   2
`define UPCS_STAT_OUTLOSS  3
`define UPCS_STAT_WRAP     6
`define UPCS_LATCH_MASK    16'h003F
`endif

/* File: hw/upcs_regs.v */
/*
  Control, status and interrupt-enable registers of the three-port
  cell interface. Assumes event inputs are one-cycle pulses from logic
  on sys_clk; alarm inputs are asynchronous levels from pins.
*/
`timescale 1ns/1ps
`include "upcs_consts.vh"
// Overview of operation
// [RQ1] Control bits 0..2 enable receive ports A, B, C.
// [RQ2] Control bits 3..5 pick PHY role (one) or SAR role (zero) per port.
// [RQ3] Bit 6 puts port A at Level 2 and disables port B.
// [RQ4] Bits 7..9: zero drives outputs only when selected; one drives always.
// [RQ5] Bit 10 zero keeps cell-available and enable pins high impedance.
// [RQ6] Software writes zero to reserved bits 14..11.
// [RQ7] Software keeps test bit 15 at zero.
// [RQ8] Status bits 0 and 1 latch PHY alarms on ports A and B.
// [RQ9] Status bit 2 latches receive reassembly FIFO cell loss.
// [RQ10] Status bits 3..5 latch output FIFO cell loss on ports A..C.
// [RQ11] Status bit 6 marks cell-loss counter wrap.
// [RQ12] Status bit 7 marks transmit segmentation arrival counter wrap.
// [RQ13] Status bit 8 marks receive reassembly departure counter wrap.
// [RQ14] Status bits 9, 11, 13 mark port A..C arrival counter wraps.
// [RQ15] Status bits 10, 12, 14 mark port A..C departure counter wraps.
// [RQ16] Status bit 15 marks raw-cell input FIFO counter wrap.
// [RQ17] Control and status reset to all zeros.
// [RQ18] Enable register at 604h; interrupt when enable and status both set.
// [RQ19] Status bits clear on the read that returns them.
// [RQ20] Level 2 ignored unless port A is in PHY role.
module upcs_regs (
  input  wire        sys_clk,
  input  wire        sys_rst,
  input  wire [11:0] reg_addr,
  input  wire [15:0] reg_wdata,
  input  wire        reg_wr,
  input  wire        reg_rd,
  output reg  [15:0] reg_rdata,
  input  wire [1:0]  phy_alarm_pin,
  input  wire        rx_sar_cell_lost,
  input  wire [2:0]  out_fifo_cell_lost,
  input  wire [9:0]  counter_wrap,
  input  wire [2:0]  port_selected,
  output reg  [2:0]  rx_port_enable,
  output reg  [2:0]  port_phy_role,
  output reg         port_a_multiphy_select,
  output reg  [2:0]  tx_data_oe_n,
  output reg         clav_enb_oe_n,
  output reg         cell_port_irq
);

  //--------------------------------------------------
  // Registers
  //--------------------------------------------------
  reg  [15:0] cell_port_control;
  reg  [15:0] cell_port_status;
  reg  [15:0] cell_port_irq_enable;
  reg  [1:0]  alarm_meta;
  reg  [1:0]  alarm_sync;
  reg  [15:0] next_status;
  reg  [15:0] next_rdata;
  wire [15:0] status_events;
  wire        multiphy_ok;
  wire        rd_status;
  wire        ctrl_wr_hit;
  wire        ie_wr_hit;
  wire        ctrl_rd_hit;
  wire        ie_rd_hit;
  wire [2:0]  ctrl_rx_enable;
  wire [2:0]  ctrl_phy_role;
  wire        ctrl_multiphy_req;
  wire [2:0]  ctrl_drive_always;
  wire        ctrl_clav_drive;
  reg  [2:0]  next_rx_port_enable;
  reg  [2:0]  next_port_phy_role;
  reg  [2:0]  next_tx_data_oe_n;
  reg         next_clav_enb_oe_n;
  reg         next_irq;

  // Low enables the pin driver of one transmit port
  function port_oe_n;
    input drive_always;
    input selected;
    input blocked;
    begin
      port_oe_n = ~((drive_always | selected) & ~blocked);
    end
  endfunction

  function hit;
    input [11:0] a;
    input [11:0] off;
    begin
      hit = (a == off);
    end
  endfunction

  //--------------------------------------------------
  // Alarm synchroniser
  //--------------------------------------------------
  // Alarms come from pins, so two flops before use
  always @(posedge sys_clk) begin
    if (sys_rst) begin
      alarm_meta <= 2'h0;
      alarm_sync <= 2'h0;
    end else begin
      alarm_meta <= phy_alarm_pin;
      alarm_sync <= alarm_meta;
    end
  end

  //--------------------------------------------------
  // Status events, one name per bit
  //--------------------------------------------------
  wire port_a_alarm_seen;
  wire port_b_alarm_seen;
  wire rx_sar_loss_seen;
  wire port_a_loss_seen;
  wire port_b_loss_seen;
  wire port_c_loss_seen;
  wire cell_loss_wrap_flag;
  wire tx_sar_arrival_wrap_flag;
  wire rx_sar_departure_wrap_flag;
  wire port_a_arrival_wrap_flag;
  wire port_a_departure_wrap_flag;
  wire port_b_arrival_wrap_flag;
  wire port_b_departure_wrap_flag;
  wire port_c_arrival_wrap_flag;
  wire port_c_departure_wrap_flag;
  wire raw_cell_fifo_wrap_flag;

  assign port_a_alarm_seen          = alarm_sync[0];          // [RQ8]
  assign port_b_alarm_seen          = alarm_sync[1];          // [RQ8]
  assign rx_sar_loss_seen           = rx_sar_cell_lost;       // [RQ9]
  assign port_a_loss_seen           = out_fifo_cell_lost[0];  // [RQ10]
  assign port_b_loss_seen           = out_fifo_cell_lost[1];  // [RQ10]
  assign port_c_loss_seen           = out_fifo_cell_lost[2];  // [RQ10]
  assign cell_loss_wrap_flag        = counter_wrap[0];        // [RQ11]
  assign tx_sar_arrival_wrap_flag   = counter_wrap[1];        // [RQ12]
  assign rx_sar_departure_wrap_flag = counter_wrap[2];        // [RQ13]
  assign port_a_arrival_wrap_flag   = counter_wrap[3];        // [RQ14]
  assign port_a_departure_wrap_flag = counter_wrap[4];        // [RQ15]
  assign port_b_arrival_wrap_flag   = counter_wrap[5];        // [RQ14]
  assign port_b_departure_wrap_flag = counter_wrap[6];        // [RQ15]
  assign port_c_arrival_wrap_flag   = counter_wrap[7];        // [RQ14]
  assign port_c_departure_wrap_flag = counter_wrap[8];        // [RQ15]
  assign raw_cell_fifo_wrap_flag    = counter_wrap[9];        // [RQ16]

  // Highest bit first, so the vector matches the status layout
  assign status_events = {raw_cell_fifo_wrap_flag,
                          port_c_departure_wrap_flag,
                          port_c_arrival_wrap_flag,
                          port_b_departure_wrap_flag,
                          port_b_arrival_wrap_flag,
                          port_a_departure_wrap_flag,
                          port_a_arrival_wrap_flag,
                          rx_sar_departure_wrap_flag,
                          tx_sar_arrival_wrap_flag,
                          cell_loss_wrap_flag,
                          port_c_loss_seen,
                          port_b_loss_seen,
                          port_a_loss_seen,
                          rx_sar_loss_seen,
                          port_b_alarm_seen,
                          port_a_alarm_seen};

  //--------------------------------------------------
  // Address decode
  //--------------------------------------------------
  assign ctrl_wr_hit = reg_wr && hit(reg_addr, `UPCS_CTRL_OFFSET);
  assign ie_wr_hit   = reg_wr && hit(reg_addr, `UPCS_IE_OFFSET);
  assign ctrl_rd_hit = reg_rd && hit(reg_addr, `UPCS_CTRL_OFFSET);
  assign rd_status   = reg_rd && hit(reg_addr, `UPCS_STAT_OFFSET);
  assign ie_rd_hit   = reg_rd && hit(reg_addr, `UPCS_IE_OFFSET);

  //--------------------------------------------------
  // Status next value
  //--------------------------------------------------
  // Set wins over the clearing read so no event is lost
  always @* begin
    next_status = cell_port_status;
    if (rd_status) begin
      next_status = 16'h0000;                      // [RQ19]
    end
    next_status = next_status | status_events;
  end

  //--------------------------------------------------
  // Status register
  //--------------------------------------------------
  always @(posedge sys_clk) begin
    if (sys_rst) begin
      cell_port_status <= `UPCS_STAT_RESET;        // [RQ17]
    end else begin
      cell_port_status <= next_status;             // [RQ19]
    end
  end

  //--------------------------------------------------
  // Control register
  //--------------------------------------------------
  always @(posedge sys_clk) begin
    if (sys_rst) begin
      cell_port_control <= `UPCS_CTRL_RESET;       // [RQ17]
    end else if (ctrl_wr_hit) begin
      // Reserved bits held at zero; test bit stored but unused
      cell_port_control <= reg_wdata & `UPCS_CTRL_WMASK; // [RQ6] [RQ7]
    end
  end

  //--------------------------------------------------
  // Interrupt enable register
  //--------------------------------------------------
  always @(posedge sys_clk) begin
    if (sys_rst) begin
      cell_port_irq_enable <= `UPCS_IE_RESET;
    end else if (ie_wr_hit) begin
      cell_port_irq_enable <= reg_wdata;           // [RQ18]
    end
  end

  //--------------------------------------------------
  // Read port
  //--------------------------------------------------
  always @* begin
    next_rdata = 16'h0000;
    // Unmapped addresses read as zero
    if (ctrl_rd_hit) begin
      next_rdata = cell_port_control;
    end else if (rd_status) begin
      next_rdata = cell_port_status;
    end else if (ie_rd_hit) begin
      next_rdata = cell_port_irq_enable;
    end
  end

  //--------------------------------------------------
  // Port control outputs
  //--------------------------------------------------
  assign ctrl_rx_enable    = cell_port_control[`UPCS_CTRL_RX_EN +: 3];
  assign ctrl_phy_role     = cell_port_control[`UPCS_CTRL_PHY_ROLE +: 3];
  assign ctrl_multiphy_req = cell_port_control[`UPCS_CTRL_MULTIPHY];
  assign ctrl_drive_always = cell_port_control[`UPCS_CTRL_DRIVE +: 3];
  assign ctrl_clav_drive   = cell_port_control[`UPCS_CTRL_CLAV_OE];

  // Level 2 without PHY role on port A would disable port B for nothing
  assign multiphy_ok = ctrl_multiphy_req & ctrl_phy_role[0];   // [RQ20]

  //--------------------------------------------------
  // Next values of the port controls
  //--------------------------------------------------
  always @* begin
    next_rx_port_enable[0] = ctrl_rx_enable[0];                 // [RQ1]
    next_rx_port_enable[1] = ctrl_rx_enable[1] & ~multiphy_ok;  // [RQ1] [RQ3]
    next_rx_port_enable[2] = ctrl_rx_enable[2];                 // [RQ1]
    next_port_phy_role     = ctrl_phy_role;                     // [RQ2]
    next_tx_data_oe_n[0]   = port_oe_n(ctrl_drive_always[0],
                                       port_selected[0], 1'b0); // [RQ4]
    // Port B released in Level 2 as port A owns the bus
    next_tx_data_oe_n[1]   = port_oe_n(ctrl_drive_always[1],
                                       port_selected[1], multiphy_ok); // [RQ3] [RQ4]
    next_tx_data_oe_n[2]   = port_oe_n(ctrl_drive_always[2],
                                       port_selected[2], 1'b0); // [RQ4]
    next_clav_enb_oe_n     = ~ctrl_clav_drive;                  // [RQ5]
    next_irq               = |(next_status & cell_port_irq_enable); // [RQ18]
  end

  //--------------------------------------------------
  // Output flops
  //--------------------------------------------------

  always @(posedge sys_clk) begin
    if (sys_rst) begin
      reg_rdata              <= 16'h0000;
      rx_port_enable         <= 3'h0;
      port_phy_role          <= 3'h0;
      port_a_multiphy_select <= 1'b0;
      tx_data_oe_n           <= 3'h7;
      clav_enb_oe_n          <= 1'b1;
      cell_port_irq          <= 1'b0;
    end else begin
      reg_rdata              <= next_rdata;
      rx_port_enable         <= next_rx_port_enable;            // [RQ1] [RQ3]
      port_phy_role          <= next_port_phy_role;             // [RQ2]
      port_a_multiphy_select <= multiphy_ok;                    // [RQ3] [RQ20]
      tx_data_oe_n           <= next_tx_data_oe_n;              // [RQ4]
      clav_enb_oe_n          <= next_clav_enb_oe_n;             // [RQ5]
      cell_port_irq          <= next_irq;                       // [RQ18]
    end
  end

endmodule // upcs_regs

/* File: bench/upcs_chk.sv */
/* Port checker for upcs_regs.
   Assumes it is bound into upcs_regs: one clock, sync reset. */
`timescale 1ns/1ps
module upcs_chk (
  input wire        sys_clk, sys_rst, reg_wr, reg_rd,
  input wire        port_a_multiphy_select, clav_enb_oe_n,
  input wire [11:0] reg_addr,
  input wire [15:0] reg_wdata, reg_rdata,
  input wire [9:0]  counter_wrap,
  input wire [2:0]  out_fifo_cell_lost, port_selected, rx_port_enable,
  input wire [2:0]  port_phy_role, tx_data_oe_n
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  sequence ctl_wr; reg_wr && reg_addr == 12'h600; endsequence
  sequence st_rd; reg_rd && reg_addr == 12'h602; endsequence
  // Pins lag a control write by two edges
  a_rx_enable: assert property (ctl_wr |-> ##2 {rx_port_enable[2], rx_port_enable[0]} ==
    $past({reg_wdata[2], reg_wdata[0]}, 2)) else $error("rx enable");
  a_phy_role: assert property (ctl_wr |-> ##2 port_phy_role == $past(reg_wdata[5:3], 2))
    else $error("role");
  a_level2_gate: assert property (ctl_wr |-> ##2 port_a_multiphy_select ==
    $past(reg_wdata[6] & reg_wdata[3], 2)) else $error("level2");
  a_level2_b_off: assert property (port_a_multiphy_select |-> !rx_port_enable[1]
    && tx_data_oe_n[1]) else $error("port b on");
  a_clav_drive: assert property (ctl_wr |-> ##2 clav_enb_oe_n == !$past(reg_wdata[10], 2))
    else $error("clav oe");
  a_sel_drive: assert property ($past(port_selected[2]) && !$past(sys_rst) |->
    !tx_data_oe_n[2]) else $error("sel drive");
  a_wrap_first: assert property (counter_wrap[0] ##1 st_rd |=> reg_rdata[6])
    else $error("wrap 6");
  a_wrap_last: assert property (counter_wrap[9] ##1 st_rd |=> reg_rdata[15])
    else $error("wrap 15");
  a_loss_port: assert property (out_fifo_cell_lost[1] ##1 st_rd |=> reg_rdata[4])
    else $error("loss b");
endmodule // upcs_chk

/* File: bench/upcs_far_end.sv */
/* Far party on the cell ports: selects ports, raises alarms.
   Assumes the bench commands it on sys_clk. */
`timescale 1ns/1ps
module upcs_far_end (
  input  wire       sys_clk,
  input  wire [2:0] sel_cmd,
  input  wire [1:0] alarm_cmd,
  output reg  [2:0] port_selected = 3'h0,
  output reg  [1:0] phy_alarm_pin = 2'h0
);
  // Alarm pins are unclocked, so move them off the edge
  always @(posedge sys_clk) begin
    port_selected <= sel_cmd;
    phy_alarm_pin <= #3 alarm_cmd;
  end
endmodule // upcs_far_end

/* File: bench/test_upcs_regs.sv */
/* Bench for upcs_regs with register read/write tasks.
   Assumes upcs_chk and upcs_far_end compiled before it. */
`timescale 1ns/1ps
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin error_cnt++; \
  $display("wrong value at %0t: %h vs %h", $time, g, e); end end
module test_upcs_regs;
  reg        sys_clk = 0, sys_rst = 1, reg_wr = 0, reg_rd = 0, rx_sar_cell_lost = 0;
  reg [11:0] reg_addr = 0;
  reg [15:0] reg_wdata = 0;
  reg [9:0]  counter_wrap = 0;
  reg [2:0]  out_fifo_cell_lost = 0, sel_cmd = 0;
  reg [1:0]  alarm_cmd = 0;
  wire [15:0] reg_rdata;
  wire [2:0] port_selected, rx_port_enable, port_phy_role, tx_data_oe_n;
  wire [1:0] phy_alarm_pin;
  wire       port_a_multiphy_select, clav_enb_oe_n, cell_port_irq;
  int        error_cnt = 0, total_checks = 0;
  always #10 sys_clk = ~sys_clk;
  upcs_far_end upcs_far_end_inst (.sys_clk, .sel_cmd, .alarm_cmd, .port_selected, .phy_alarm_pin);
  upcs_regs upcs_regs_inst (.sys_clk, .sys_rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .phy_alarm_pin, .rx_sar_cell_lost, .out_fifo_cell_lost, .counter_wrap,
    .port_selected, .rx_port_enable, .port_phy_role, .port_a_multiphy_select, .tx_data_oe_n,
    .clav_enb_oe_n, .cell_port_irq);
  task wr(input [11:0] a, input [15:0] v);
    reg_wr <= 1; reg_addr <= a; reg_wdata <= v;
    @(posedge sys_clk) reg_wr <= 0;
  endtask
  task rd(input [11:0] a, input [15:0] e);
    reg_rd <= 1; reg_addr <= a;
    @(posedge sys_clk) reg_rd <= 0;
    #1 `CHK(reg_rdata, e)
  endtask
  task ev(input [9:0] w, input [2:0] o, input r);
    counter_wrap <= w; out_fifo_cell_lost <= o; rx_sar_cell_lost <= r;
    @(posedge sys_clk) counter_wrap <= 0;
    out_fifo_cell_lost <= 0;
    rx_sar_cell_lost <= 0;
  endtask
  task end_of_test;
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    #5000 error_cnt++;
    end_of_test;
  end
  initial begin
    repeat (2) @(posedge sys_clk);
    sys_rst <= 0;
    @(posedge sys_clk);
    rd(12'h600, 16'h0000);
    rd(12'h602, 16'h0000);
    wr(12'h606, 16'hFFFF);
    rd(12'h606, 16'h0000);
    wr(12'h600, 16'h07FF);
    rd(12'h600, 16'h07FF);
    `CHK({rx_port_enable, port_phy_role, port_a_multiphy_select}, 7'b1011111)
    `CHK({tx_data_oe_n, clav_enb_oe_n}, 4'b0100)
    sel_cmd <= 3'b100;
    wr(12'h600, 16'h0047);
    rd(12'h600, 16'h0047);
    `CHK({rx_port_enable, port_phy_role, port_a_multiphy_select}, 7'b1110000)
    `CHK({tx_data_oe_n, clav_enb_oe_n}, 4'b0111)
    alarm_cmd <= 2'b11;
    wr(12'h604, 16'h0010);
    repeat (4) @(posedge sys_clk);
    `CHK(cell_port_irq, 1'b0)
    ev(10'h3FF, 3'b111, 1'b1);
    #1 `CHK(cell_port_irq, 1'b1)
    rd(12'h602, 16'hFFFF);
    `CHK(cell_port_irq, 1'b0)
    alarm_cmd <= 2'b00;
    repeat (5) @(posedge sys_clk);
    rd(12'h602, 16'h0003);
    rd(12'h602, 16'h0000);
    end_of_test;
  end
endmodule // test_upcs_regs
bind upcs_regs upcs_chk upcs_chk_inst (.sys_clk, .sys_rst, .reg_wr, .reg_rd, .reg_addr,
  .reg_wdata, .reg_rdata, .counter_wrap, .out_fifo_cell_lost, .port_selected, .rx_port_enable,
  .port_phy_role, .port_a_multiphy_select, .tx_data_oe_n, .clav_enb_oe_n);
